/* dv/pct_link_assertions.sv */
`timescale 1ns/100ps
`include "pct_consts.svh"

// ==================================================
// Link protocol checks
module pct_link_assertions (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link signals
  input wire logic msg_valid,
  input wire logic [`PCT_MSG_W-1:0] msg_code,
  input wire logic ack_valid
);
  localparam int TRANS_MIN = `PCT_SRC_TRANS_CYC;
  logic rdy_due_reg;
  logic [15:0] since_ack_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Accept seen and its ready message still owed
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) rdy_due_reg <= 1'b0;
    else if (msg_valid) rdy_due_reg <= (msg_code == `PCT_MSG_ACCEPT);
  end

  // Saturates so a slow supply cannot wrap it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) since_ack_reg <= 16'h0000;
    else if (ack_valid) since_ack_reg <= 16'h0000;
    else if (since_ack_reg != 16'hFFFF)
      since_ack_reg <= since_ack_reg + 16'h0001;
  end

  sequence s_accept;
    msg_valid && msg_code == `PCT_MSG_ACCEPT;
  endsequence
  sequence s_rdy;
    msg_valid && msg_code == `PCT_MSG_PS_RDY;
  endsequence

  a_accept_ack_two: assert property (s_accept |-> ##2 ack_valid)
    else $error("accept not acknowledged two cycles later");
  a_rdy_ack_two: assert property (s_rdy |-> ##2 ack_valid)
    else $error("ready message not acknowledged two cycles later");
  a_msg_one_cycle: assert property (msg_valid |=> !msg_valid)
    else $error("message strobe longer than one cycle");
  a_ack_one_cycle: assert property (ack_valid |=> !ack_valid)
    else $error("acknowledge longer than one cycle");
  a_code_known: assert property (msg_valid |-> msg_code inside
    {`PCT_MSG_ACCEPT, `PCT_MSG_PS_RDY})
    else $error("message with unknown code");
  a_ack_has_msg: assert property (ack_valid |-> $past(msg_valid, 2))
    else $error("acknowledge without a message");
  a_rdy_after_acc: assert property (s_rdy |-> rdy_due_reg)
    else $error("ready message without accept");
  a_acc_not_owed: assert property (s_accept |-> !rdy_due_reg)
    else $error("accept while ready message owed");
  a_rdy_waits_trans: assert property (s_rdy |->
    since_ack_reg >= TRANS_MIN)
    else $error("ready message before transition wait");
endmodule

/* dv/power_contract_transition_seq_tb.sv */
`timescale 1ns/100ps
`include "pct_consts.svh"

// ==================================================
// Both ends joined, user sides driven here
module power_contract_transition_seq_tb;
  import pct_pkg::*;
  localparam int N = 6;
  localparam int TRANS = `PCT_SRC_TRANS_CYC;
  localparam int STDBY = `PCT_SNK_STDBY_CYC;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic supply_ready_i = 1'b0;
  logic standby_done_i = 1'b0;
  logic supply_cmd_o, busy_o, done_o, ready_late_o;
  logic standby_cmd_o, new_power_ok_o, standby_late_o, timeout_o;
  int n_errors = 0;
  int n_tests = 0;
  int n_acc = 0;
  int n_rdy = 0;
  int cyc = 0;
  int w, gap, t_ack;

  pct_link_if link ();
  pct_source u_pct_source (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(link), .req_i(req_i), .supply_ready_i(supply_ready_i),
    .supply_cmd_o(supply_cmd_o), .busy_o(busy_o), .done_o(done_o),
    .ready_late_o(ready_late_o));
  pct_sink u_pct_sink (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(link), .standby_done_i(standby_done_i),
    .standby_cmd_o(standby_cmd_o), .new_power_ok_o(new_power_ok_o),
    .standby_late_o(standby_late_o), .timeout_o(timeout_o));
  pct_link_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .msg_valid(link.msg_valid), .msg_code(link.msg_code),
    .ack_valid(link.ack_valid));

  always #5 clk_sys_i = ~clk_sys_i;

  // Message tally and hang guard at cycle 40000; six rounds of a little over 2500 cycles each
  always @(posedge clk_sys_i) begin
    cyc++;
    if (link.msg_valid === 1'b1) begin
      if (link.msg_code === `PCT_MSG_ACCEPT) n_acc++;
      if (link.msg_code === `PCT_MSG_PS_RDY) n_rdy++;
    end
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  // Standby counts as late if never reached or past its window
  function automatic logic exp_late(input int g);
    return g < 0 || g > STDBY;
  endfunction

  function automatic logic sel(input int k);
    case (k)
      0: return link.msg_valid;
      1: return link.ack_valid;
      2: return supply_cmd_o;
      default: return !busy_o;
    endcase
  endfunction

  // Bounded wait, values read once the edge has settled
  task automatic wait_on(input int k, output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (sel(k) !== 1'b1 && n < 3000);
    check("handshake wait", n < 3000, 1);
  endtask

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(28157));
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < N; i++) begin
      // Last round never reports standby
      gap = (i == N - 1) ? -1 : 1 + $urandom % (STDBY / 2);
      @(posedge clk_sys_i);
      req_i <= 1'b1;
      standby_done_i <= 1'b0;
      @(posedge clk_sys_i);
      req_i <= 1'b0;
      wait_on(0, w);
      check("accept code", link.msg_code, `PCT_MSG_ACCEPT);
      wait_on(1, w);
      t_ack = cyc;
      check("accept ack gap", w, 2);
      @(posedge clk_sys_i);
      #1;
      check("standby cmd", standby_cmd_o, 1);
      // Request while busy must be dropped
      @(posedge clk_sys_i);
      req_i <= 1'b1;
      @(posedge clk_sys_i);
      req_i <= 1'b0;
      if (gap > 0) begin
        repeat (gap) @(posedge clk_sys_i);
        standby_done_i <= 1'b1;
      end
      wait_on(2, w);
      check("trans wait", cyc - t_ack >= TRANS &&
        cyc - t_ack <= TRANS + 1, 1);
      check("standby late", standby_late_o, exp_late(gap));
      repeat (3 + $urandom % 50) @(posedge clk_sys_i);
      check("no early ready", n_rdy, i);
      supply_ready_i <= 1'b1;
      @(posedge clk_sys_i);
      supply_ready_i <= 1'b0;
      wait_on(0, w);
      check("ready code", link.msg_code, `PCT_MSG_PS_RDY);
      wait_on(1, w);
      check("ready ack gap", w, 2);
      @(posedge clk_sys_i);
      #1;
      check("done", done_o, 1);
      check("new power ok", new_power_ok_o, 1);
      check("standby released", standby_cmd_o, 0);
      wait_on(3, w);
    end
    check("accept count", n_acc, N);
    check("ready count", n_rdy, N);
    check("ready late", ready_late_o, 0);
    check("sink timeout", timeout_o, 0);
    tally_and_finish();
  end
endmodule

/* verilog/pct_consts.svh */
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH

// ==================================================================
// Message codes on the link
`define PCT_MSG_W 2
`define PCT_MSG_ACCEPT 2'h1
`define PCT_MSG_PS_RDY 2'h2
`define PCT_MSG_NONE 2'h0

// ==================================================================
// Timing, figures in microseconds, counts at 100 MHz
`define PCT_CLK_MHZ 100
`define PCT_CNT_W 24
// Source transition wait, minimum
`define PCT_T_SRC_TRANS_US 25
`define PCT_SRC_TRANS_CYC (`PCT_T_SRC_TRANS_US * `PCT_CLK_MHZ)
// Source supply ready, maximum
`define PCT_T_SRC_READY_US 275000
`define PCT_SRC_READY_CYC (`PCT_T_SRC_READY_US * `PCT_CLK_MHZ)
// Sink standby reduction, maximum
`define PCT_T_SNK_STDBY_US 15
`define PCT_SNK_STDBY_CYC (`PCT_T_SNK_STDBY_US * `PCT_CLK_MHZ)
// Sink transition timer, maximum wait for supply ready message
`define PCT_T_PS_TRANS_US 500000
`define PCT_PS_TRANS_CYC (`PCT_T_PS_TRANS_US * `PCT_CLK_MHZ)
// Longest wait for an acknowledge before the source gives up
`define PCT_ACK_WAIT_CYC 8'h10

`endif

/* verilog/pct_link_if.sv */
`timescale 1ns/100ps
`include "pct_consts.svh"

// ==================================================================
// Message link between the two policy engines
interface pct_link_if;
  logic msg_valid;
  logic [`PCT_MSG_W-1:0] msg_code;
  logic ack_valid;

  modport source (output msg_valid, output msg_code, input ack_valid);
  modport sink (input msg_valid, input msg_code, output ack_valid);
endinterface

/* verilog/pct_pkg.sv */
package pct_pkg;
  // ================================================================
  // Source end states
  typedef enum logic [2:0] {
    PCT_SRC_IDLE = 3'b000,
    PCT_SRC_SEND_ACC = 3'b001,
    PCT_SRC_WAIT_ACK = 3'b010,
    PCT_SRC_TRANS = 3'b011,
    PCT_SRC_SUPPLY = 3'b100,
    PCT_SRC_SEND_RDY = 3'b101,
    PCT_SRC_WAIT_ACK2 = 3'b110
  } pct_src_state_t;

  // ================================================================
  // Sink end states
  typedef enum logic [2:0] {
    PCT_SNK_IDLE = 3'b000,
    PCT_SNK_ACK_ACC = 3'b001,
    PCT_SNK_EVAL_ACC = 3'b010,
    PCT_SNK_WAIT_RDY = 3'b011,
    PCT_SNK_ACK_RDY = 3'b100,
    PCT_SNK_EVAL_RDY = 3'b101
  } pct_snk_state_t;
endpackage

/* verilog/pct_sink.sv */
`timescale 1ns/100ps
`include "pct_consts.svh"

// ==================================================================
// Sink end of the contract transition
module pct_sink
  import pct_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link to the source
  pct_link_if.sink link,
  // Device policy manager side
  input wire logic standby_done_i,
  output logic standby_cmd_o,
  output logic new_power_ok_o,
  output logic standby_late_o,
  output logic timeout_o
);

  pct_snk_state_t state_reg;
  logic [`PCT_CNT_W+4:0] ps_cnt_reg;
  logic [`PCT_CNT_W-1:0] stby_cnt_reg;
  logic ack_reg;
  logic stby_wait_reg;

  localparam logic [`PCT_CNT_W+4:0] PS_CYC =
    (`PCT_CNT_W+5)'(`PCT_PS_TRANS_CYC);
  localparam logic [`PCT_CNT_W-1:0] STBY_CYC =
    `PCT_CNT_W'(`PCT_SNK_STDBY_CYC);

  // ================================================================
  // Sequence control; acknowledge always precedes evaluation
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PCT_SNK_IDLE;
    end else begin
      case (state_reg)
        PCT_SNK_IDLE: begin
          if (link.msg_valid && link.msg_code == `PCT_MSG_ACCEPT) begin
            state_reg <= PCT_SNK_ACK_ACC;
          end
        end
        PCT_SNK_ACK_ACC: begin
          state_reg <= PCT_SNK_EVAL_ACC;
        end
        PCT_SNK_EVAL_ACC: begin
          state_reg <= PCT_SNK_WAIT_RDY;
        end
        PCT_SNK_WAIT_RDY: begin
          if (link.msg_valid && link.msg_code == `PCT_MSG_PS_RDY) begin
            state_reg <= PCT_SNK_ACK_RDY;
          end else if (ps_cnt_reg == PS_CYC) begin
            state_reg <= PCT_SNK_IDLE;
          end
        end
        PCT_SNK_ACK_RDY: begin
          state_reg <= PCT_SNK_EVAL_RDY;
        end
        PCT_SNK_EVAL_RDY: begin
          state_reg <= PCT_SNK_IDLE;
        end
        default: begin
          state_reg <= PCT_SNK_IDLE;
        end
      endcase
    end
  end

  // Transition timer, started by Accept, stopped by the ready message
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ps_cnt_reg <= '0;
      timeout_o <= 1'b0;
    end else if (state_reg == PCT_SNK_IDLE) begin
      ps_cnt_reg <= '0;
    end else if (state_reg == PCT_SNK_ACK_ACC) begin
      ps_cnt_reg <= '0;
      timeout_o <= 1'b0;
    end else if (state_reg == PCT_SNK_WAIT_RDY) begin
      if (ps_cnt_reg == PS_CYC) begin
        timeout_o <= 1'b1;
      end else begin
        ps_cnt_reg <= ps_cnt_reg + (`PCT_CNT_W+5)'(1);
      end
    end
  end

  // Acknowledge strobes, one cycle per received message
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (state_reg == PCT_SNK_ACK_ACC) ||
        (state_reg == PCT_SNK_ACK_RDY);
    end
  end

  assign link.ack_valid = ack_reg;

  // Standby command and its deadline check
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      standby_cmd_o <= 1'b0;
      stby_wait_reg <= 1'b0;
      stby_cnt_reg <= '0;
      standby_late_o <= 1'b0;
    end else if (state_reg == PCT_SNK_EVAL_ACC) begin
      standby_cmd_o <= 1'b1;
      stby_wait_reg <= 1'b1;
      stby_cnt_reg <= '0;
      standby_late_o <= 1'b0;
    end else begin
      if (state_reg == PCT_SNK_EVAL_RDY) begin
        standby_cmd_o <= 1'b0;
      end
      if (stby_wait_reg) begin
        if (standby_done_i) begin
          stby_wait_reg <= 1'b0;
        end else if (stby_cnt_reg == STBY_CYC) begin
          standby_late_o <= 1'b1;
          stby_wait_reg <= 1'b0;
        end else begin
          stby_cnt_reg <= stby_cnt_reg + `PCT_CNT_W'(1);
        end
      end
    end
  end

  // Permission to draw new power; load ramp is left to the manager
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      new_power_ok_o <= 1'b0;
    end else if (state_reg == PCT_SNK_EVAL_RDY) begin
      new_power_ok_o <= 1'b1;
    end else if (state_reg == PCT_SNK_ACK_ACC) begin
      new_power_ok_o <= 1'b0;
    end
  end

endmodule

/* verilog/pct_source.sv */
`timescale 1ns/100ps
`include "pct_consts.svh"

// Notes on behaviour
// - Source answers request by sending Accept
// - Sink starts transition timer on Accept
// - After Accept acknowledged, wait transition time
// - Sink acknowledges Accept before evaluating it
// - Sink drops to standby within its window
// - Sink keeps transient load limits
// - After wait, command supply voltage change
// - Supply must be ready within ready time
// - Supply ready status reaches the engine
// - Send supply ready message after status
// - Sink acknowledges then permits new power
// - Sink may start new load anytime
// - Sink load change duration is variable
module pct_source
  import pct_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link to the sink
  pct_link_if.source link,
  // Device policy manager side
  input wire logic req_i,
  input wire logic supply_ready_i,
  output logic supply_cmd_o,
  output logic busy_o,
  output logic done_o,
  output logic ready_late_o
);

  // ================================================================
  // State and timers
  pct_src_state_t state_reg;
  logic [`PCT_CNT_W-1:0] trans_cnt_reg;
  logic [`PCT_CNT_W+3:0] ready_cnt_reg;
  logic msg_valid_reg;
  logic [`PCT_MSG_W-1:0] msg_code_reg;
  // Acknowledge watchdog, guards against a sink that never answers
  logic [7:0] ack_cnt_reg;
  logic ack_lost;

  // Timer limits, cut to the counter widths on purpose
  localparam logic [7:0] ACK_CYC = `PCT_ACK_WAIT_CYC;
  localparam logic [`PCT_CNT_W-1:0] TRANS_CYC =
    `PCT_CNT_W'(`PCT_SRC_TRANS_CYC);
  localparam logic [`PCT_CNT_W+3:0] READY_CYC =
    (`PCT_CNT_W+4)'(`PCT_SRC_READY_CYC);

  // ================================================================
  // Sequence control
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PCT_SRC_IDLE;
    end else begin
      case (state_reg)
        PCT_SRC_IDLE: begin
          if (req_i) begin
            state_reg <= PCT_SRC_SEND_ACC;
          end
        end
        PCT_SRC_SEND_ACC: begin
          state_reg <= PCT_SRC_WAIT_ACK;
        end
        PCT_SRC_WAIT_ACK: begin
          if (link.ack_valid) begin
            state_reg <= PCT_SRC_TRANS;
          end else if (ack_lost) begin
            // No acknowledge: drop the transition, supply untouched
            state_reg <= PCT_SRC_IDLE;
          end
        end
        PCT_SRC_TRANS: begin
          if (trans_cnt_reg == TRANS_CYC - `PCT_CNT_W'(1)) begin
            state_reg <= PCT_SRC_SUPPLY;
          end
        end
        PCT_SRC_SUPPLY: begin
          // Holds here until status arrives, even past the deadline
          if (supply_ready_i) begin
            state_reg <= PCT_SRC_SEND_RDY;
          end
        end
        PCT_SRC_SEND_RDY: begin
          state_reg <= PCT_SRC_WAIT_ACK2;
        end
        PCT_SRC_WAIT_ACK2: begin
          if (link.ack_valid) begin
            state_reg <= PCT_SRC_IDLE;
          end else if (ack_lost) begin
            // Supply already moved; only the report is lost
            state_reg <= PCT_SRC_IDLE;
          end
        end
        default: begin
          state_reg <= PCT_SRC_IDLE;
        end
      endcase
    end
  end

  // ================================================================
  // Acknowledge watchdog
  // A lost acknowledge would otherwise hold the engine busy for good;
  // giving up returns to idle so that a later request can retry
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_cnt_reg <= 8'h00;
    end else if ((state_reg == PCT_SRC_WAIT_ACK ||
        state_reg == PCT_SRC_WAIT_ACK2) && !link.ack_valid) begin
      if (ack_cnt_reg != ACK_CYC) begin
        ack_cnt_reg <= ack_cnt_reg + 8'h01; // Saturates at the limit
      end
    end else begin
      ack_cnt_reg <= 8'h00;
    end
  end

  // Watchdog expiry, read by the sequence control
  assign ack_lost = (ack_cnt_reg == ACK_CYC);

  // ================================================================
  // Transition wait
  // Counts only while waiting; cleared elsewhere so that each
  // transition gets the full wait, never a remainder
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trans_cnt_reg <= '0;
    end else if (state_reg == PCT_SRC_TRANS) begin
      trans_cnt_reg <= trans_cnt_reg + `PCT_CNT_W'(1);
    end else begin
      trans_cnt_reg <= '0;
    end
  end

  // ================================================================
  // Supply ready deadline
  // Only flags lateness; the engine keeps waiting for the status,
  // since a ready message without it would be worse than a late one
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ready_cnt_reg <= '0;
      ready_late_o <= 1'b0;
    end else if (state_reg == PCT_SRC_SUPPLY) begin
      if (ready_cnt_reg != READY_CYC) begin
        ready_cnt_reg <= ready_cnt_reg + (`PCT_CNT_W+4)'(1);
      end else begin
        ready_late_o <= 1'b1;
      end
    end else begin
      ready_cnt_reg <= '0;
      if (state_reg == PCT_SRC_SEND_ACC) begin
        ready_late_o <= 1'b0;
      end
    end
  end

  // ================================================================
  // Message strobes
  // One cycle each toward the sink
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      msg_valid_reg <= 1'b0;
      msg_code_reg <= `PCT_MSG_NONE;
    end else if (state_reg == PCT_SRC_SEND_ACC) begin
      msg_valid_reg <= 1'b1;
      msg_code_reg <= `PCT_MSG_ACCEPT;
    end else if (state_reg == PCT_SRC_SEND_RDY) begin
      msg_valid_reg <= 1'b1;
      msg_code_reg <= `PCT_MSG_PS_RDY;
    end else begin
      msg_valid_reg <= 1'b0;
      msg_code_reg <= `PCT_MSG_NONE;
    end
  end

  assign link.msg_valid = msg_valid_reg;
  assign link.msg_code = msg_code_reg;

  // ================================================================
  // Status outputs
  // All registered so the policy manager sees clean levels
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      supply_cmd_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      supply_cmd_o <= (state_reg == PCT_SRC_TRANS) &&
        (trans_cnt_reg == TRANS_CYC - `PCT_CNT_W'(1));
      busy_o <= (state_reg != PCT_SRC_IDLE);
      done_o <= (state_reg == PCT_SRC_WAIT_ACK2) && link.ack_valid;
    end
  end

endmodule
